// >>> src/ctu_top.sv
// Charge-time unit control registers, edge logic and AXI4-Lite slave
//
// Added by the designer: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/100ps
// Summary of operation
// - Module disable stops the unit clock
// - Any reset clears every unit register
// - Reset abandons a running measurement
// - Enable bit seven turns unit on
// - Stop-in-idle halts unit during idle
// - Bit four enables delay pulse mode
// - Edge gating passes or blocks edges
// - Ordering makes edge two wait edge one
// - Discharge bit grounds current source
// - Trigger bit enables special event trigger
// - Second edge polarity: rising or falling
// - Second edge source: pins or triggers
// - First edge polarity: rising or falling
// - First edge source uses same encoding
// - Second status set by qualifying edge
// - First status set by qualifying edge
// - Six-bit signed trim code
// - Two-bit range, zero disables source
// - Bit six reads zero, ignores writes
// - Charge between first and second status
`include "ctu_defines.svh"

module ctu_top
(
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic [31:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output ctu_pkg::ctu_resp_t s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [31:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output ctu_pkg::ctu_resp_t s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic edge_pin_one_i,
    input wire logic edge_pin_two_i,
    input wire logic first_capture_compare_i,
    input wire logic second_capture_compare_i,
    input wire logic device_idle_i,
    output logic unit_clk_en_o,
    output logic charge_enable_o,
    output logic source_discharge_o,
    output logic special_trigger_o,
    output logic delay_pulse_enable_o,
    output logic [1:0] current_range_o,
    output logic [5:0] current_trim_o
);
    import ctu_pkg::*;

    ctu_state_t s_reg;
    ctu_state_t s_next;
    logic [1:0] rst_sync_reg;
    logic rst_n;

    // Level of the source chosen by a two-bit select code
    function automatic logic pick_src(input ctu_src_sel_t sel,
                                      input logic [3:0] lvl);
        return lvl[sel];
    endfunction

    // Edge of the programmed polarity between two samples
    function automatic logic edge_hit(input logic pol, input logic now,
                                      input logic was);
        return pol ? (now & ~was) : (~now & was);
    endfunction

    // Release of reset goes through two flops; assertion stays async
    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            rst_sync_reg <= 2'h0;
        else
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
    assign rst_n = rst_sync_reg[1];

    logic [3:0] lvl;
    logic running;
    logic gate_open;
    logic ev1;
    logic ev2;
    logic wr_do;
    logic wr_ok;
    logic [3:0] rd_ofs;
    logic rd_ok;
    logic [7:0] rd_val;
    logic both_now;
    logic both_next;

    always_comb
    begin
        s_next = s_reg;
        // Index 3 is pin one so the select code indexes directly
        lvl = {s_reg.pin1_level, s_reg.pin2_level,
               first_capture_compare_i, second_capture_compare_i};
        // Pins: first flop feeds only the second; change needs 2 and 3 equal
        s_next.pin1_sync = {s_reg.pin1_sync[1:0], edge_pin_one_i};
        s_next.pin2_sync = {s_reg.pin2_sync[1:0], edge_pin_two_i};
        if (s_reg.pin1_sync[1] == s_reg.pin1_sync[2])
            s_next.pin1_level = s_reg.pin1_sync[2];
        if (s_reg.pin2_sync[1] == s_reg.pin2_sync[2])
            s_next.pin2_level = s_reg.pin2_sync[2];
        s_next.src_prev = lvl;

        running = s_reg.ctl_high[`CTU_HI_ENABLE] && !s_reg.mod_dis
            && !(s_reg.ctl_high[`CTU_HI_STOP_IDLE] && device_idle_i);
        gate_open = running && s_reg.ctl_high[`CTU_HI_EDGE_GATING];
        ev1 = gate_open && edge_hit(s_reg.edge_low[`CTU_LO_POL1],
            pick_src(s_reg.edge_low[`CTU_LO_SRC1_MSB:`CTU_LO_SRC1_LSB],
                     lvl),
            pick_src(s_reg.edge_low[`CTU_LO_SRC1_MSB:`CTU_LO_SRC1_LSB],
                     s_reg.src_prev));
        ev2 = gate_open && edge_hit(s_reg.edge_low[`CTU_LO_POL2],
            pick_src(s_reg.edge_low[`CTU_LO_SRC2_MSB:`CTU_LO_SRC2_LSB],
                     lvl),
            pick_src(s_reg.edge_low[`CTU_LO_SRC2_MSB:`CTU_LO_SRC2_LSB],
                     s_reg.src_prev))
            && (!s_reg.ctl_high[`CTU_HI_ORDERING]
                || s_reg.edge_low[`CTU_LO_STAT1]);

        // Write channel: address and data taken in either order
        if (s_axi_awvalid_i && s_reg.aw_rdy)
        begin
            s_next.aw_have = 1'b1;
            s_next.aw_rdy = 1'b0;
            s_next.aw_addr = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && s_reg.w_rdy)
        begin
            s_next.w_have = 1'b1;
            s_next.w_rdy = 1'b0;
            s_next.w_data = s_axi_wdata_i[7:0];
            s_next.w_lane0 = s_axi_wstrb_i[0];
        end
        wr_do = s_reg.aw_have && s_reg.w_have && !s_reg.bvalid;
        wr_ok = s_reg.aw_addr[31:4] == 28'h000_0000;
        if (wr_do)
        begin
            s_next.aw_have = 1'b0;
            s_next.w_have = 1'b0;
            s_next.bvalid = 1'b1;
            s_next.bresp = wr_ok ? `CTU_RESP_OKAY : `CTU_RESP_SLVERR;
        end
        if (s_reg.bvalid && s_axi_bready_i)
        begin
            s_next.bvalid = 1'b0;
            s_next.aw_rdy = 1'b1;
            s_next.w_rdy = 1'b1;
        end
        // Unit registers freeze while its clock is withdrawn
        if (wr_do && wr_ok && s_reg.w_lane0)
        begin
            unique case (s_reg.aw_addr[3:0])
                `CTU_OFS_CTL_HIGH:
                    if (!s_reg.mod_dis)
                        s_next.ctl_high = s_reg.w_data
                            & `CTU_HI_WRITE_MASK;
                `CTU_OFS_EDGE_LOW:
                    if (!s_reg.mod_dis)
                        s_next.edge_low = s_reg.w_data;
                `CTU_OFS_CUR_CTL:
                    if (!s_reg.mod_dis)
                        s_next.cur_ctl = s_reg.w_data;
                `CTU_OFS_MOD_DIS:
                    s_next.mod_dis = s_reg.w_data[0];
                default:
                    s_next.mod_dis = s_reg.mod_dis;
            endcase
        end
        // Hardware set wins over a software clear in the same cycle
        if (ev1)
            s_next.edge_low[`CTU_LO_STAT1] = 1'b1;
        if (ev2)
            s_next.edge_low[`CTU_LO_STAT2] = 1'b1;

        // Read channel: one read outstanding, data captured on accept
        rd_ofs = s_axi_araddr_i[3:0];
        rd_ok = s_axi_araddr_i[31:4] == 28'h000_0000;
        unique case (rd_ofs)
            `CTU_OFS_CTL_HIGH: rd_val = s_reg.ctl_high;
            `CTU_OFS_EDGE_LOW: rd_val = s_reg.edge_low;
            `CTU_OFS_CUR_CTL: rd_val = s_reg.cur_ctl;
            `CTU_OFS_MOD_DIS: rd_val = {7'h00, s_reg.mod_dis};
            default:
            begin
                rd_val = 8'h00;
                rd_ok = 1'b0;
            end
        endcase
        if (s_axi_arvalid_i && s_reg.ar_rdy)
        begin
            s_next.ar_rdy = 1'b0;
            s_next.rvalid = 1'b1;
            s_next.rdata = rd_ok ? rd_val : 8'h00;
            s_next.rresp = rd_ok ? `CTU_RESP_OKAY : `CTU_RESP_SLVERR;
        end
        if (s_reg.rvalid && s_axi_rready_i)
        begin
            s_next.rvalid = 1'b0;
            s_next.ar_rdy = 1'b1;
        end

        // Clock, discharge and charge follow the settled next state, one flop each; trigger takes its enables from the current state
        s_next.clk_en = !s_next.mod_dis;
        s_next.discharge = !s_next.mod_dis
            && s_next.ctl_high[`CTU_HI_DISCHARGE];
        // Stop-in-idle shuts the current source, not the registers
        s_next.charge = s_next.ctl_high[`CTU_HI_ENABLE] && !s_next.mod_dis
            && !(s_next.ctl_high[`CTU_HI_STOP_IDLE] && device_idle_i)
            && !s_next.ctl_high[`CTU_HI_DISCHARGE]
            && s_next.cur_ctl[`CTU_CUR_RANGE_MSB:`CTU_CUR_RANGE_LSB]
               != CTU_RANGE_OFF
            && s_next.edge_low[`CTU_LO_STAT1]
            && !s_next.edge_low[`CTU_LO_STAT2];
        both_now = s_reg.edge_low[`CTU_LO_STAT1]
            && s_reg.edge_low[`CTU_LO_STAT2];
        both_next = s_next.edge_low[`CTU_LO_STAT1]
            && s_next.edge_low[`CTU_LO_STAT2];
        s_next.trig = running && s_reg.ctl_high[`CTU_HI_TRIG_EN]
            && both_next && !both_now;
    end

    // Reset clears everything but clk_en and the ready flags, which it sets; a running measurement leaves no trace
    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_reg <= '0;
            s_reg.ctl_high <= `CTU_RST_CTL_HIGH;
            s_reg.edge_low <= `CTU_RST_EDGE_LOW;
            s_reg.cur_ctl <= `CTU_RST_CUR_CTL;
            s_reg.clk_en <= 1'b1;
            s_reg.aw_rdy <= 1'b1;
            s_reg.w_rdy <= 1'b1;
            s_reg.ar_rdy <= 1'b1;
        end
        else
            s_reg <= s_next;
    end

    assign s_axi_awready_o = s_reg.aw_rdy;
    assign s_axi_wready_o = s_reg.w_rdy;
    assign s_axi_bvalid_o = s_reg.bvalid;
    assign s_axi_bresp_o = s_reg.bresp;
    assign s_axi_arready_o = s_reg.ar_rdy;
    assign s_axi_rvalid_o = s_reg.rvalid;
    assign s_axi_rresp_o = s_reg.rresp;
    assign s_axi_rdata_o = {24'h00_0000, s_reg.rdata};
    assign unit_clk_en_o = s_reg.clk_en;
    assign charge_enable_o = s_reg.charge;
    assign source_discharge_o = s_reg.discharge;
    assign special_trigger_o = s_reg.trig;
    assign delay_pulse_enable_o = s_reg.ctl_high[`CTU_HI_DELAY_PULSE];
    assign current_range_o =
        s_reg.cur_ctl[`CTU_CUR_RANGE_MSB:`CTU_CUR_RANGE_LSB];
    assign current_trim_o =
        s_reg.cur_ctl[`CTU_CUR_TRIM_MSB:`CTU_CUR_TRIM_LSB];

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n);

    logic sw_low_wr;
    assign sw_low_wr = wr_do && wr_ok && s_reg.w_lane0
        && s_reg.aw_addr[3:0] == `CTU_OFS_EDGE_LOW;

    AST_RESET_CLEAR: assert property (
        $rose(rst_n) |-> s_reg.ctl_high == 8'h00 && !charge_enable_o)
        else $error("Unit registers not cleared by reset");
    AST_BIT6_ZERO: assert property (
        s_reg.ctl_high[`CTU_HI_UNUSED] == 1'b0)
        else $error("Unused control bit read as one");
    AST_MOD_DIS_CLK: assert property (
        s_reg.mod_dis |-> !unit_clk_en_o && !charge_enable_o)
        else $error("Unit clock or charge active while disabled");
    AST_OFF_NO_CHARGE: assert property (
        !s_reg.ctl_high[`CTU_HI_ENABLE] |-> !charge_enable_o)
        else $error("Charging while unit disabled");
    AST_IDLE_STOP: assert property (
        s_reg.ctl_high[`CTU_HI_STOP_IDLE] && device_idle_i
        |=> !charge_enable_o)
        else $error("Charging through idle with stop-in-idle set");
    AST_DISCHARGE: assert property (
        s_reg.ctl_high[`CTU_HI_DISCHARGE] && !s_reg.mod_dis
        |-> source_discharge_o && !charge_enable_o)
        else $error("Discharge bit not grounding source");
    AST_GATED: assert property (
        !s_reg.ctl_high[`CTU_HI_EDGE_GATING] && !sw_low_wr
        |=> $stable(s_reg.edge_low[1:0]))
        else $error("Status changed with edges blocked");
    AST_ORDER: assert property (
        s_reg.ctl_high[`CTU_HI_ORDERING] && !s_reg.edge_low[0]
        && !s_reg.edge_low[1] && !sw_low_wr |=> !s_reg.edge_low[1])
        else $error("Second edge taken before first");
    AST_HW_SET: assert property (
        $rose(s_reg.edge_low[0]) && !$past(sw_low_wr) |-> $past(gate_open))
        else $error("First status set with gate closed");
    AST_TRIG_PULSE: assert property (
        special_trigger_o |=> !special_trigger_o)
        else $error("Special trigger longer than one cycle");
    AST_TRIG_EN: assert property (
        special_trigger_o |-> $past(s_reg.ctl_high[`CTU_HI_TRIG_EN]))
        else $error("Special trigger while disabled");
    AST_RANGE_OFF: assert property (
        current_range_o == 2'h0 |-> !charge_enable_o)
        else $error("Charging with current source off");
    AST_CHARGE: assert property (
        charge_enable_o |-> s_reg.edge_low[0] && !s_reg.edge_low[1])
        else $error("Charge outside first-to-second window");
    AST_BRESP: assert property (
        wr_do |=> s_axi_bvalid_o)
        else $error("Write response missing");
    AST_STAT2_HW: assert property (
        $rose(s_reg.edge_low[1]) && !$past(sw_low_wr) |-> $past(gate_open))
        else $error("Second status set with gate closed");
    AST_TRIG_SEQ: assert property (
        special_trigger_o |-> s_reg.edge_low[0] && s_reg.edge_low[1])
        else $error("Special trigger without completed sequence");
    AST_DIS_QUIET: assert property (
        s_reg.mod_dis |-> !source_discharge_o)
        else $error("Source grounded while unit disabled");
    AST_RESET_OUT: assert property (
        $rose(rst_n) |-> unit_clk_en_o && !source_discharge_o
        && !special_trigger_o && current_range_o == 2'h0)
        else $error("Unit outputs not at defaults after reset");

    COV_CHARGE: cover property (!charge_enable_o ##1 charge_enable_o);
    COV_TRIG: cover property (special_trigger_o);
    COV_WRITE: cover property (s_axi_bvalid_o && s_axi_bready_i);
    COV_READ: cover property (s_axi_rvalid_o && s_axi_rready_i);
    COV_MOD_DIS: cover property ($rose(s_reg.mod_dis));
endmodule

// >>> common/ctu_defines.svh
// Register offsets, field positions and reset values of the unit
`ifndef CTU_DEFINES_SVH
`define CTU_DEFINES_SVH

`define CTU_OFS_CTL_HIGH 4'h0
`define CTU_OFS_EDGE_LOW 4'h4
`define CTU_OFS_CUR_CTL 4'h8
`define CTU_OFS_MOD_DIS 4'hC

`define CTU_RST_CTL_HIGH 8'h00
`define CTU_RST_EDGE_LOW 8'h00
`define CTU_RST_CUR_CTL 8'h00

`define CTU_HI_ENABLE 7
`define CTU_HI_UNUSED 6
`define CTU_HI_STOP_IDLE 5
`define CTU_HI_DELAY_PULSE 4
`define CTU_HI_EDGE_GATING 3
`define CTU_HI_ORDERING 2
`define CTU_HI_DISCHARGE 1
`define CTU_HI_TRIG_EN 0

`define CTU_LO_POL2 7
`define CTU_LO_SRC2_MSB 6
`define CTU_LO_SRC2_LSB 5
`define CTU_LO_POL1 4
`define CTU_LO_SRC1_MSB 3
`define CTU_LO_SRC1_LSB 2
`define CTU_LO_STAT2 1
`define CTU_LO_STAT1 0

`define CTU_CUR_TRIM_MSB 7
`define CTU_CUR_TRIM_LSB 2
`define CTU_CUR_RANGE_MSB 1
`define CTU_CUR_RANGE_LSB 0

`define CTU_HI_WRITE_MASK 8'hBF
`define CTU_RESP_OKAY 2'h0
`define CTU_RESP_SLVERR 2'h2

`endif

// >>> common/ctu_pkg.sv
// Types shared by the charge-time unit control logic
package ctu_pkg;
    typedef logic [1:0] ctu_src_sel_t;
    typedef logic [1:0] ctu_resp_t;

    typedef enum logic [1:0]
    {
        CTU_RANGE_OFF = 2'h0,
        CTU_RANGE_X1 = 2'h1,
        CTU_RANGE_X10 = 2'h2,
        CTU_RANGE_X100 = 2'h3
    } ctu_range_t;

    typedef struct packed
    {
        logic [7:0] ctl_high;
        logic [7:0] edge_low;
        logic [7:0] cur_ctl;
        logic mod_dis;
        logic [2:0] pin1_sync;
        logic [2:0] pin2_sync;
        logic pin1_level;
        logic pin2_level;
        logic [3:0] src_prev;
        logic charge;
        logic discharge;
        logic trig;
        logic clk_en;
        logic aw_rdy;
        logic w_rdy;
        logic aw_have;
        logic w_have;
        logic [31:0] aw_addr;
        logic [7:0] w_data;
        logic w_lane0;
        logic bvalid;
        ctu_resp_t bresp;
        logic ar_rdy;
        logic rvalid;
        logic [7:0] rdata;
        ctu_resp_t rresp;
    } ctu_state_t;
endpackage

// >>> dv/charge_time_unit_control_bench.sv
// Self-checking bench for the charge-time unit control block
`timescale 1ns/100ps
module charge_time_unit_control_bench;
    import ctu_pkg::*;
    localparam int LIMIT = 20000;
    // Trim codes packed low first: 1F, 00, 21, 3F
    localparam logic [23:0] TRIM = 24'hFE_101F;
    logic clk = 1'b0;
    logic nrst = 1'b1;
    logic [31:0] awaddr = 32'h0000_0000, wdata = 32'h0000_0000;
    logic [31:0] araddr = 32'h0000_0000;
    logic [3:0] wstrb = 4'h0;
    logic [3:0] ev = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, idle = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic clk_en, charge, dis, trig, dpe;
    logic [31:0] rdata;
    ctu_resp_t bresp, rresp;
    logic [1:0] rng;
    logic [5:0] trim;
    int bad_count = 0, n_tests = 0, cyc = 0, trig_n = 0;

    ctu_top DUT (.ref_clk_i(clk), .nrst_i(nrst),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
        .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
        .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .edge_pin_one_i(ev[3]),
        .edge_pin_two_i(ev[2]), .first_capture_compare_i(ev[1]),
        .second_capture_compare_i(ev[0]), .device_idle_i(idle),
        .unit_clk_en_o(clk_en), .charge_enable_o(charge),
        .source_discharge_o(dis), .special_trigger_o(trig),
        .delay_pulse_enable_o(dpe), .current_range_o(rng),
        .current_trim_o(trim));

    always #10 clk = ~clk;

    // Pulse counter; the trigger stands one cycle only
    always @(posedge clk)
        if (trig === 1'b1)
            trig_n++;

    task automatic close_out;
        $display("Mismatches %0d of %0d comparisons", bad_count, n_tests);
        if (bad_count == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == LIMIT)
        begin
            bad_count++;
            $display("ERROR %0t timeout", $time);
            close_out;
        end
    end

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        n_tests++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR %0t flag %b expected %b", $time, got, exp);
        end
    endtask

    task automatic axi_wr(input logic [31:0] a, input logic [7:0] d,
                          input logic [3:0] s, output ctu_resp_t r);
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h00_0000, d};
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever
        begin
            @(posedge clk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            if (bvalid)
            begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic axi_rd(input logic [31:0] a, output logic [31:0] d,
                          output ctu_resp_t r);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever
        begin
            @(posedge clk);
            if (arvalid && arready)
                arvalid <= 1'b0;
            if (rvalid)
            begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        ctu_resp_t r;
        axi_wr({28'h000_0000, a}, d, 4'h1, r);
        chk_val({30'h0000_0000, r}, 32'h0000_0000);
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
        logic [31:0] d;
        ctu_resp_t r;
        axi_rd({28'h000_0000, a}, d, r);
        chk_val(d, exp);
    endtask

    task automatic rd_bit(input int b, input logic exp);
        logic [31:0] d;
        ctu_resp_t r;
        axi_rd(32'h0000_0004, d, r);
        chk_bit(d[b], exp);
    endtask

    // Eight cycles covers pin synchroniser plus status update
    task automatic ev_set(input int s, input logic v);
        @(posedge clk);
        ev[s] <= v;
        repeat (8) @(posedge clk);
    endtask

    task automatic t_regs;
        rd_chk(4'h0, 32'h0000_0000);
        rd_chk(4'h4, 32'h0000_0000);
        chk_bit(clk_en, 1'b1);
        wr(4'h0, 8'hFF);
        rd_chk(4'h0, 32'h0000_00BF);
        chk_bit(dpe, 1'b1);
        chk_bit(dis, 1'b1);
        wr(4'h0, 8'h88);
        chk_bit(dpe, 1'b0);
        chk_bit(dis, 1'b0);
        for (int i = 0; i < 4; i++)
        begin
            wr(4'h8, {TRIM[i*6 +: 6], 2'(i)});
            chk_val({30'h0000_0000, rng}, 32'(i));
            chk_val({26'h000_0000, trim}, {26'h000_0000, TRIM[i*6 +: 6]});
        end
    endtask

    task automatic t_sources;
        logic [7:0] v;
        logic [1:0] q;
        for (int e = 0; e < 2; e++)
            for (int s = 0; s < 4; s++)
            begin
                q = 2'(s);
                v = (e == 1) ? {q[0], q, 5'h00} : {3'h0, q[0], q, 2'h0};
                ev_set(s, q[0]);
                wr(4'h4, v);
                ev_set(s, ~q[0]);
                rd_bit(e, 1'b0);
                ev_set(s, q[0]);
                rd_bit(e, 1'b1);
            end
    endtask

    task automatic t_order;
        int n;
        n = trig_n;
        ev_set(1, 1'b0);
        ev_set(0, 1'b0);
        wr(4'h0, 8'h8C);
        wr(4'h4, 8'hB0);
        ev_set(1, 1'b1);
        rd_chk(4'h4, 32'h0000_00B0);
        ev_set(0, 1'b1);
        rd_chk(4'h4, 32'h0000_00B1);
        chk_bit(charge, 1'b1);
        ev_set(1, 1'b0);
        ev_set(1, 1'b1);
        rd_chk(4'h4, 32'h0000_00B3);
        chk_bit(charge, 1'b0);
        chk_val(32'(trig_n), 32'(n));
        wr(4'h0, 8'h80);
        wr(4'h4, 8'hB0);
        ev_set(0, 1'b0);
        ev_set(0, 1'b1);
        rd_chk(4'h4, 32'h0000_00B0);
    endtask

    task automatic t_trigger;
        int n;
        wr(4'h0, 8'h09);
        wr(4'h4, 8'hB1);
        n = trig_n;
        wr(4'h4, 8'hB3);
        repeat (2) @(posedge clk);
        chk_val(32'(trig_n), 32'(n));
        wr(4'h0, 8'h89);
        wr(4'h4, 8'hB1);
        wr(4'h4, 8'hB3);
        repeat (2) @(posedge clk);
        chk_val(32'(trig_n), 32'(n + 1));
        wr(4'h4, 8'hB1);
        wr(4'h0, 8'h8B);
        chk_bit(charge, 1'b0);
        chk_bit(dis, 1'b1);
    endtask

    task automatic t_idle_dis;
        wr(4'h0, 8'hA8);
        wr(4'h4, 8'hB0);
        @(posedge clk);
        idle <= 1'b1;
        ev_set(0, 1'b0);
        ev_set(0, 1'b1);
        rd_chk(4'h4, 32'h0000_00B0);
        wr(4'h0, 8'h88);
        ev_set(0, 1'b0);
        ev_set(0, 1'b1);
        rd_chk(4'h4, 32'h0000_00B1);
        idle <= 1'b0;
        wr(4'hC, 8'h01);
        chk_bit(clk_en, 1'b0);
        wr(4'h0, 8'h80);
        rd_chk(4'h0, 32'h0000_0088);
        wr(4'hC, 8'h00);
        chk_bit(clk_en, 1'b1);
    endtask

    task automatic t_bus_reset;
        ctu_resp_t r;
        logic [31:0] d;
        axi_wr(32'h0000_0010, 8'hFF, 4'h1, r);
        chk_val({30'h0000_0000, r}, 32'h0000_0002);
        axi_rd(32'h0000_0014, d, r);
        chk_val({30'h0000_0000, r}, 32'h0000_0002);
        axi_wr(32'h0000_0000, 8'h00, 4'h0, r);
        rd_chk(4'h0, 32'h0000_0088);
        wr(4'h8, 8'h01);
        wr(4'h4, 8'h01);
        chk_bit(charge, 1'b1);
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        chk_bit(charge, 1'b0);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        rd_chk(4'h4, 32'h0000_0000);
        rd_chk(4'h8, 32'h0000_0000);
        wr(4'h0, 8'h02);
        chk_bit(dis, 1'b1);
        wr(4'h0, 8'h00);
    endtask

    initial
    begin
        // Falling edge at time zero clears the design before any sample
        nrst <= 1'b0;
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        t_regs;
        t_sources;
        t_order;
        t_trigger;
        t_idle_dis;
        t_bus_reset;
        close_out;
    end
endmodule
